// [hdl/breaker_pkg.sv]
// Purpose: shared constants and carriers for the two-slot breaker logic
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: cycle counts derive from the printed times and the clock rate
package breaker_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_KHZ = 40_000;
  localparam int DIGITAL_TRIP_DELAY_MS = 40;
  localparam int AUTO_RETRY_DELAY_MS = 820;
  localparam int LATCH_DEBOUNCE_MS = 10;
  localparam int CNT_W = 26;
  localparam logic [CNT_W-1:0] DIGITAL_TRIP_CYCLES = CNT_W'(CLK_KHZ * DIGITAL_TRIP_DELAY_MS);
  localparam logic [CNT_W-1:0] AUTO_RETRY_CYCLES = CNT_W'(CLK_KHZ * AUTO_RETRY_DELAY_MS);
  localparam logic [CNT_W-1:0] LATCH_DEBOUNCE_CYCLES = CNT_W'(CLK_KHZ * LATCH_DEBOUNCE_MS);
  localparam logic [CNT_W-1:0] CNT_RESET = 26'h0000000;
  localparam int NUM_SLOTS = 2;

  // ****************************************************************
  // per-slot carriers
  // ****************************************************************
  typedef struct packed {
    logic main_req;          // main rails request, high = on
    logic aux_rail_request;  // aux rail request, high = on
    logic card_latch_sw_n;   // card latch switch, low = latched
    logic supply_12v_ok;     // main_supply_12v_in above lockout
    logic supply_3v_ok;      // main_supply_3v_in above lockout
    logic standby_ok;        // standby_supply_in present
    logic main_ilim;         // main current above limit threshold
    logic main_fast;         // main sense above fast_trip_level
    logic aux_ilim;          // aux rail in current regulation
    logic cap_expired;       // trip_delay_cap_pin reached its threshold
    logic cap_grounded;      // trip_delay_cap_pin tied to ground
  } slot_pins_t;

  typedef struct packed {
    logic main_rail_en;      // gate enable for both main rails
    logic aux_rail_out;      // aux rail switch enable
    logic main_fault_n;      // main fault, low = asserted
    logic aux_fault_n;       // aux fault, low = asserted
    logic cap_charge;        // start charging the trip_delay_cap_pin
    logic standby;           // slot in standby operation
  } slot_status_t;

  localparam slot_status_t STATUS_RESET = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

endpackage

// [hdl/pin_sync.sv]
// Purpose: two-flop synchroniser for a vector of asynchronous pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [hdl/slot_breaker.sv]
// Purpose: fault and circuit-breaker sequencing for two card slots
// Assumes: comparator and request pins are asynchronous; one 40 MHz clock
// Notes: long counts are top parameters so a simulation can shorten them
`timescale 1ns/1ps
module slot_breaker
  import breaker_pkg::*;
#(
  parameter logic [CNT_W-1:0] DIGITAL_TRIP_P = DIGITAL_TRIP_CYCLES,
  parameter logic [CNT_W-1:0] AUTO_RETRY_P = AUTO_RETRY_CYCLES,
  parameter logic [CNT_W-1:0] LATCH_DEBOUNCE_P = LATCH_DEBOUNCE_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire slot_pins_t [NUM_SLOTS-1:0] slot_pins_in,
  input wire logic over_temp_140_in,
  input wire logic over_temp_160_in,
  input wire logic auto_retry_mode_in,
  output slot_status_t [NUM_SLOTS-1:0] slot_status_out,
  output logic irq_n_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic cnt_last(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] limit);
    cnt_last = (cnt == limit - 26'h0000001);
  endfunction

  // sticky flag: a set in the same cycle as the clear wins
  function automatic logic sticky(input logic set, input logic hold,
                                  input logic clr);
    sticky = set | (hold & ~clr);
  endfunction

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  localparam int PIN_W = $bits(slot_pins_t) * NUM_SLOTS + 3;

  logic [PIN_W-1:0] pins_sync;
  slot_pins_t [NUM_SLOTS-1:0] pin_s;
  logic hot_140_s;
  logic hot_160_s;
  logic retry_mode_s;
  logic [NUM_SLOTS-1:0] irq_pend;

  pin_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({slot_pins_in, over_temp_140_in, over_temp_160_in, auto_retry_mode_in}),
    .sync_out(pins_sync)
  );

  assign {pin_s, hot_140_s, hot_160_s, retry_mode_s} = pins_sync;

  // ****************************************************************
  // per-slot breaker
  // ****************************************************************
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    logic main_req_prev_q;
    logic aux_req_prev_q;
    logic [CNT_W-1:0] debounce_cnt_q;
    logic latch_ok_q;
    logic [CNT_W-1:0] dig_cnt_q;
    logic [CNT_W-1:0] aux_cnt_q;
    logic [CNT_W-1:0] retry_cnt_q;
    logic main_trip_q;
    logic main_trip_d;
    logic aux_trip_q;
    logic aux_trip_d;
    logic main_en_q;
    logic main_en_d;
    logic aux_en_q;
    logic aux_en_d;
    logic main_fault_q;
    logic aux_fault_q;
    logic irq_q;
    logic main_fault_d;
    logic aux_fault_d;
    logic irq_d;
    logic standby;
    logic main_fell;
    logic aux_fell;
    logic ilim_active;
    logic analog_done;
    logic digital_done;
    logic main_trip_ev;
    logic aux_ilim_active;
    logic aux_trip_ev;
    logic retry_done;

    // edge detection of the synchronised requests
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        main_req_prev_q <= 1'b0;
        aux_req_prev_q <= 1'b0;
      end else begin
        main_req_prev_q <= pin_s[i].main_req;
        aux_req_prev_q <= pin_s[i].aux_rail_request;
      end
    end

    assign main_fell = fell(main_req_prev_q, pin_s[i].main_req);
    assign aux_fell = fell(aux_req_prev_q, pin_s[i].aux_rail_request);

    // card latch debounce: must stay low for the full count
    always_ff @(posedge clk_in) begin
      if (sys_rst_in || pin_s[i].card_latch_sw_n) begin
        debounce_cnt_q <= CNT_RESET;
        latch_ok_q <= 1'b0;
      end else if (cnt_last(debounce_cnt_q, LATCH_DEBOUNCE_P)) begin
        latch_ok_q <= 1'b1;
      end else begin
        debounce_cnt_q <= debounce_cnt_q + 26'h0000001;
      end
    end

    assign standby = ~(pin_s[i].supply_12v_ok & pin_s[i].supply_3v_ok);

    // ****************************************************************
    // overcurrent and thermal trips
    // ****************************************************************
    // primary overcurrent: analog and digital delays race
    assign ilim_active = main_en_q & pin_s[i].main_ilim;
    // a grounded cap pin reads as expired at once, so it is ignored
    assign analog_done = pin_s[i].cap_expired & ~pin_s[i].cap_grounded;
    assign digital_done = cnt_last(dig_cnt_q, DIGITAL_TRIP_P);

    always_ff @(posedge clk_in) begin
      if (sys_rst_in || !ilim_active) begin
        dig_cnt_q <= CNT_RESET;
      end else if (!digital_done) begin
        dig_cnt_q <= dig_cnt_q + 26'h0000001;
      end
    end

    assign main_trip_ev = main_en_q & (
      (ilim_active & (analog_done | digital_done)) |
      pin_s[i].main_fast |
      standby);

    // aux overcurrent: timer only, no fast path
    assign aux_ilim_active = aux_en_q & pin_s[i].aux_ilim;

    always_ff @(posedge clk_in) begin
      if (sys_rst_in || !aux_ilim_active) begin
        aux_cnt_q <= CNT_RESET;
      end else if (!cnt_last(aux_cnt_q, DIGITAL_TRIP_P)) begin
        aux_cnt_q <= aux_cnt_q + 26'h0000001;
      end
    end

    // thermal: only a slot whose aux rail is in overcurrent is shut down
    assign aux_trip_ev = aux_ilim_active & (cnt_last(aux_cnt_q, DIGITAL_TRIP_P) |
                                            hot_140_s |
                                            hot_160_s);

    // auto-retry counter runs while tripped in the retry variant
    assign retry_done = retry_mode_s & cnt_last(retry_cnt_q, AUTO_RETRY_P);

    always_ff @(posedge clk_in) begin
      if (sys_rst_in || !retry_mode_s || !(main_trip_q || aux_trip_q)) begin
        retry_cnt_q <= CNT_RESET;
      end else if (!retry_done) begin
        retry_cnt_q <= retry_cnt_q + 26'h0000001;
      end
    end

    // trip flags: a new trip wins over any clear in the same cycle
    always_comb begin
      main_trip_d = main_trip_q;
      aux_trip_d = aux_trip_q;
      if (main_fell || retry_done || !pin_s[i].standby_ok) begin
        main_trip_d = 1'b0;
      end
      if (aux_fell || retry_done || !pin_s[i].standby_ok) begin
        aux_trip_d = 1'b0;
      end
      if (main_trip_ev) begin
        main_trip_d = 1'b1;
      end
      if (aux_trip_ev) begin
        aux_trip_d = 1'b1;
      end
    end

    // an aux trip also holds the main rails off until aux is cycled, a retry completes or standby_ok drops
    assign main_en_d = pin_s[i].main_req & latch_ok_q & ~standby &
                       ~main_trip_d & ~aux_trip_d;
    assign aux_en_d = pin_s[i].aux_rail_request & latch_ok_q &
                      pin_s[i].standby_ok & ~aux_trip_d;

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        main_trip_q <= 1'b0;
        aux_trip_q <= 1'b0;
      end else begin
        main_trip_q <= main_trip_d;
        aux_trip_q <= aux_trip_d;
      end
    end

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        main_en_q <= 1'b0;
        aux_en_q <= 1'b0;
      end else begin
        main_en_q <= main_en_d;
        aux_en_q <= aux_en_d;
      end
    end

    // ****************************************************************
    // fault and interrupt flags
    // ****************************************************************
    // next values feed both the flags and the output registers, so a
    // fault pin and the shared interrupt move on the same edge
    assign main_fault_d = sticky(main_trip_ev, main_fault_q, main_fell);
    assign aux_fault_d = sticky(aux_trip_ev, aux_fault_q, aux_fell);
    assign irq_d = sticky(main_trip_ev | aux_trip_ev, irq_q,
                          main_fell | aux_fell);
    assign irq_pend[i] = irq_d;

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        main_fault_q <= 1'b0;
      end else begin
        main_fault_q <= main_fault_d;
      end
    end

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        aux_fault_q <= 1'b0;
      end else begin
        aux_fault_q <= aux_fault_d;
      end
    end

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        irq_q <= 1'b0;
      end else begin
        irq_q <= irq_d;
      end
    end

    // ****************************************************************
    // slot outputs
    // ****************************************************************
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        slot_status_out[i] <= STATUS_RESET;
      end else begin
        slot_status_out[i].main_rail_en <= main_en_d;
        slot_status_out[i].aux_rail_out <= aux_en_d;
        slot_status_out[i].main_fault_n <= ~main_fault_d;
        slot_status_out[i].aux_fault_n <= ~aux_fault_d;
        slot_status_out[i].cap_charge <= main_en_d & pin_s[i].main_ilim;
        slot_status_out[i].standby <= standby;
      end
    end
  end

  // ****************************************************************
  // shared interrupt
  // ****************************************************************
  // active low; takes the next pending values so it lands with the fault
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~(|irq_pend);
    end
  end

endmodule

// [test/host_ctrl_model.sv]
// Purpose: hot-plug controller model driving the slot request inputs
// Assumes: the bench sets commands between clock edges
// Notes: requests change just after a rising edge, like a clocked driver
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic clk_in,
  input wire logic [1:0] main_cmd_in,
  input wire logic [1:0] aux_cmd_in,
  output logic [1:0] main_req_out,
  output logic [1:0] aux_req_out
);
  // ****************************************************************
  // request drivers
  // ****************************************************************
  initial begin
    main_req_out = 2'h0;
    aux_req_out = 2'h0;
  end
  // the bench drops main before the second supply_3v_ok loss only, and runs full cycles after trips
  always @(posedge clk_in) begin
    main_req_out <= main_cmd_in;
    aux_req_out <= aux_cmd_in;
  end
endmodule

// [test/slot_breaker_bench.sv]
// Purpose: directed tests of the two-slot breaker logic
// Assumes: short counts: trip 8, retry 20, debounce 4 cycles
// Notes: status checks use {en,aux,mfault_n,afault_n,charge,standby}
`timescale 1ns/1ps
module slot_breaker_bench;
  import breaker_pkg::*;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic clk_in = 1'b0;
  logic rst = 1'b1;
  logic t140 = 1'b0;
  logic t160 = 1'b0;
  logic arm = 1'b0;
  logic [1:0] mc = 2'h0;
  logic [1:0] ac = 2'h0;
  logic [1:0] mreq;
  logic [1:0] areq;
  slot_pins_t [1:0] p = {2{11'h1e1}};
  slot_pins_t [1:0] pins;
  slot_status_t [1:0] st;
  logic irq_n;
  int miscompares = 0;
  int check_count = 0;
  initial forever #12.5 clk_in = ~clk_in;
  always_comb begin
    pins = p;
    for (int i = 0; i < 2; i++) begin
      pins[i].main_req = mreq[i];
      pins[i].aux_rail_request = areq[i];
    end
  end
  host_ctrl_model u_host (.clk_in(clk_in), .main_cmd_in(mc), .aux_cmd_in(ac),
    .main_req_out(mreq), .aux_req_out(areq));
  slot_breaker #(.DIGITAL_TRIP_P(26'h8), .AUTO_RETRY_P(26'h14), .LATCH_DEBOUNCE_P(26'h4)) u_dut (
    .clk_in(clk_in), .sys_rst_in(rst), .slot_pins_in(pins), .over_temp_140_in(t140),
    .over_temp_160_in(t160), .auto_retry_mode_in(arm), .slot_status_out(st), .irq_n_out(irq_n));
  task step(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task cs(input int s, input logic [5:0] e);
    check_count++;
    if (st[s] !== e) begin
      miscompares++;
      $display("Error at %0t: status %h expected %h", $time, st[s], e);
    end
  endtask
  task ci(input logic e);
    check_count++;
    if (irq_n !== e) begin
      miscompares++;
      $display("Error at %0t: irq_n %h expected %h", $time, irq_n, e);
    end
  endtask
  // a full high-low-high cycle; long gaps keep it clear of the synchroniser
  task reen(input logic [1:0] m, input logic [1:0] a);
    mc = mc & ~m;
    ac = ac & ~a;
    step(8);
    mc = mc | m;
    ac = ac | a;
    step(8);
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(negedge clk_in);
    miscompares++;
    close_out();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    step(12);
    rst = 1'b0;
    mc = 2'h3;
    ac = 2'h3;
    step(10);
    cs(0, 6'h0c);
    p[0].card_latch_sw_n = 1'b0;
    p[1].card_latch_sw_n = 1'b0;
    step(12);
    cs(0, 6'h3c);
    cs(1, 6'h3c);
    $display("test bring_up done");
    p[0].main_fast = 1'b1;
    step(5);
    cs(0, 6'h14);
    ci(1'b0);
    p[0].main_fast = 1'b0;
    step(5);
    cs(0, 6'h14);
    mc[0] = 1'b0;
    step(8);
    cs(0, 6'h1c);
    ci(1'b1);
    mc[0] = 1'b1;
    step(8);
    cs(0, 6'h3c);
    $display("test fast_trip done");
    p[0].cap_expired = 1'b1;
    p[0].main_ilim = 1'b1;
    step(5);
    cs(0, 6'h3e);
    step(10);
    cs(0, 6'h14);
    p[0].main_ilim = 1'b0;
    reen(2'h1, 2'h0);
    cs(0, 6'h3c);
    $display("test digital_delay done");
    p[0].cap_grounded = 1'b0;
    p[0].main_ilim = 1'b1;
    step(5);
    cs(0, 6'h14);
    ci(1'b0);
    p[0].main_ilim = 1'b0;
    p[0].cap_expired = 1'b0;
    p[0].cap_grounded = 1'b1;
    reen(2'h1, 2'h0);
    cs(0, 6'h3c);
    ci(1'b1);
    $display("test analog_delay done");
    p[0].supply_3v_ok = 1'b0;
    step(6);
    cs(0, 6'h15);
    ci(1'b0);
    p[0].supply_3v_ok = 1'b1;
    reen(2'h1, 2'h0);
    mc[0] = 1'b0;
    step(6);
    p[0].supply_3v_ok = 1'b0;
    step(6);
    cs(0, 6'h1d);
    ci(1'b1);
    p[0].supply_3v_ok = 1'b1;
    mc[0] = 1'b1;
    step(8);
    cs(0, 6'h3c);
    $display("test undervoltage done");
    p[0].aux_ilim = 1'b1;
    t140 = 1'b1;
    step(6);
    cs(0, 6'h08);
    cs(1, 6'h3c);
    t140 = 1'b0;
    p[1].aux_ilim = 1'b1;
    t160 = 1'b1;
    step(6);
    cs(1, 6'h08);
    t160 = 1'b0;
    p[0].aux_ilim = 1'b0;
    p[1].aux_ilim = 1'b0;
    reen(2'h3, 2'h3);
    cs(1, 6'h3c);
    $display("test thermal done");
    p[0].aux_ilim = 1'b1;
    step(5);
    cs(0, 6'h3c);
    step(10);
    cs(0, 6'h08);
    ci(1'b0);
    p[0].aux_ilim = 1'b0;
    reen(2'h1, 2'h1);
    cs(0, 6'h3c);
    ci(1'b1);
    $display("test aux_timer done");
    p[0].main_fast = 1'b1;
    step(5);
    p[0].main_fast = 1'b0;
    p[0].standby_ok = 1'b0;
    step(5);
    cs(0, 6'h24);
    p[0].standby_ok = 1'b1;
    step(5);
    cs(0, 6'h34);
    ci(1'b0);
    reen(2'h1, 2'h0);
    cs(0, 6'h3c);
    $display("test supply_cycle done");
    arm = 1'b1;
    p[0].main_fast = 1'b1;
    step(5);
    p[0].main_fast = 1'b0;
    step(30);
    cs(0, 6'h34);
    ci(1'b0);
    arm = 1'b0;
    reen(2'h1, 2'h0);
    cs(0, 6'h3c);
    $display("test auto_retry done");
    close_out();
  end
endmodule

// [test/slot_breaker_checker.sv]
// Purpose: port-level checks on slot 0 of the breaker logic
// Assumes: binds to slot_breaker, one clock domain
// Notes: slot 1 is covered by the bench comparisons
`timescale 1ns/1ps
module slot_breaker_checker
  import breaker_pkg::*;
#(
  parameter logic [CNT_W-1:0] DIGITAL_TRIP_P = DIGITAL_TRIP_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire slot_pins_t [NUM_SLOTS-1:0] slot_pins_in,
  input wire logic over_temp_140_in,
  input wire logic over_temp_160_in,
  input wire logic auto_retry_mode_in,
  input wire slot_status_t [NUM_SLOTS-1:0] slot_status_out,
  input wire logic irq_n_out
);
  // ****************************************************************
  // helpers and assertions
  // ****************************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire slot_pins_t p0 = slot_pins_in[0];
  wire slot_pins_t p1 = slot_pins_in[1];
  wire slot_status_t s0 = slot_status_out[0];
  wire all_req = p0.main_req & p0.aux_rail_request & p1.main_req & p1.aux_rail_request;
  logic [CNT_W-1:0] hi_q;
  // charge time counter: the trip must cut charging at the digital limit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !s0.cap_charge) begin
      hi_q <= 26'h0;
    end else begin
      hi_q <= hi_q + 26'h1;
    end
  end
  // five samples: two sync stages, the debounce flag, then the output flop
  latch_blocks_a: assert property (
    p0.card_latch_sw_n [*5] |-> !s0.main_rail_en && !s0.aux_rail_out)
    else $error("enable with card latch open");
  fast_kill_a: assert property (
    p0.main_fast [*4] |-> !s0.main_rail_en)
    else $error("main on during fast trip");
  irq_with_fault_a: assert property (
    $fell(s0.main_fault_n) |-> !irq_n_out)
    else $error("irq not raised with main fault");
  aux_irq_a: assert property (
    $fell(s0.aux_fault_n) |-> !irq_n_out)
    else $error("irq not raised with aux fault");
  irq_hold_a: assert property (
    all_req [*8] |-> !$rose(irq_n_out))
    else $error("irq released without request fall");
  aux_trip_a: assert property (
    $fell(s0.aux_fault_n) |-> !s0.aux_rail_out && !s0.main_rail_en)
    else $error("aux trip left a rail on");
  aux_by_req_a: assert property (
    $rose(s0.aux_rail_out) |->
      $past(p0.aux_rail_request, 2) || $past(p0.aux_rail_request, 3))
    else $error("aux on without request");
  standby_off_a: assert property (
    s0.standby |-> !s0.main_rail_en)
    else $error("main on in standby");
  uv_fault_a: assert property (
    $rose(s0.standby) && $past(s0.main_rail_en) |-> !s0.main_fault_n)
    else $error("no fault on brown-out");
  trip_bound_a: assert property (
    hi_q <= DIGITAL_TRIP_P + 26'h2)
    else $error("digital delay overrun");
  fast_cov: cover property ($fell(s0.main_fault_n));
  aux_cov: cover property ($fell(s0.aux_fault_n));
  stby_cov: cover property ($rose(s0.standby));
endmodule
bind slot_breaker slot_breaker_checker #(.DIGITAL_TRIP_P(DIGITAL_TRIP_P)) u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .slot_pins_in(slot_pins_in),
  .over_temp_140_in(over_temp_140_in), .over_temp_160_in(over_temp_160_in),
  .auto_retry_mode_in(auto_retry_mode_in), .slot_status_out(slot_status_out),
  .irq_n_out(irq_n_out));
